// *** inc/pwr_rst_consts.svh ***
// Purpose: Offsets, fields, defaults and timing counts of the power block
// Assumes: 8-bit registers, index = bus address
// Notes:   Definitions only
`ifndef PWR_RST_CONSTS_SVH
`define PWR_RST_CONSTS_SVH

`define ADDR_W          5
`define REG_FIRST       5'h01
`define REG_LAST        5'h11
`define REG_CODEC1_CTRL 5'h02
`define REG_MIC_GAIN    5'h05
`define REG_SIDETONE    5'h06
`define REG_CODEC2_CTRL 5'h07
`define REG_SPK_GAIN    5'h0A
`define REG_SPK_DRV     5'h0B
`define REG_HS_DRV      5'h0D
`define REG_ANALOG      5'h0E
`define REG_STATUS      5'h12

`define BIT_SW_RESET    7
`define BIT_CODEC_PD    6
`define BIT_ANALOG_PD   7
`define BIT_HD_DRV_PD   6
`define BIT_LN_DRV_PD   5
`define BIT_DRV_PD      7

`define GAIN_HS_LSB     0
`define GAIN_HD_LSB     2
`define SIDE_HS_LSB     0
`define SIDE_HD_LSB     4

`define SIDETONE_14DB   4'h4
`define REG_DEFAULT     8'h00
`define SIDETONE_DEFAULT {`SIDETONE_14DB, `SIDETONE_14DB}

`define RST_WAIT_US     10
`define CLK_MHZ         40
`define RST_WAIT_CYC    (`RST_WAIT_US * `CLK_MHZ)
`define PD_WAIT_FRAMES  2'h2
`define FRAME_BCLKS     9'h100
`define SLOT_BCLKS      16

`endif

// *** inc/pwr_rst_pkg.sv ***
// Purpose: Types shared by the power-down and reset control block
// Assumes: Constants come from pwr_rst_consts.svh
// Notes:   Gain codes follow the preamplifier settings
package pwr_rst_pkg;

  typedef enum logic [1:0] {
    MIC_0DB, MIC_14DB, MIC_23DB, MIC_MUTE
  } mic_gain_e;

  typedef enum logic [2:0] {
    SPK_0DB, SPK_20DB, SPK_32DB, SPK_42DB, SPK_MUTE
  } spk_gain_e;

  typedef enum {
    LNK_RST_WAIT, LNK_PD_WAIT, LNK_SWR_WAIT, LNK_READY
  } link_state_e;

  typedef struct packed {
    logic hw_pd;
    logic codec1_pd;
    logic codec2_pd;
    logic analog_pd;
    logic handset_drv_pd;
    logic headset_drv_pd;
    logic line_drv_pd;
    logic speaker_drv_pd;
  } pd_ctrl_s;

  typedef struct packed {
    mic_gain_e handset_mic_input;
    mic_gain_e headset_mic_input;
    spk_gain_e speakerphone_mic_input;
    logic [3:0] handset_sidetone;
    logic [3:0] headset_sidetone;
  } gain_ctrl_s;

endpackage

// *** rtl/codec_power_reset.sv ***
// Purpose: Power-down and reset control for a dual voice codec
// Assumes: Pins power_down_pin, frame_sync and bit_clk are asynchronous
// Notes:   Host waits are tracked and shown on host_ready
//
// The address-and-strobe port and the register offsets were decided locally.
`include "pwr_rst_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module codec_power_reset
  import pwr_rst_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [`ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [7:0]          reg_rdata,
  input  wire logic                power_down_pin,
  input  wire logic                frame_sync,
  input  wire logic                bit_clk,
  output pd_ctrl_s                 pd_ctrl,
  output gain_ctrl_s               gain_ctrl,
  output logic      [3:0]          frame_slot,
  output logic      [7:0]          codec1_frames,
  output logic      [7:0]          codec2_frames,
  output logic                     codec1_reset,
  output logic                     codec2_reset,
  output logic                     host_ready
);

  localparam int WAIT_CYC = `RST_WAIT_CYC;

  // Register group membership; used by the software-reset next-value logic only
  function automatic logic in_group1(input logic [`ADDR_W-1:0] a);
    in_group1 = (a >= 5'h01 && a <= 5'h05) || a == 5'h0F;
  endfunction

  function automatic logic in_group2(input logic [`ADDR_W-1:0] a);
    in_group2 = (a >= 5'h06 && a <= 5'h0E) || a == 5'h10 || a == 5'h11;
  endfunction

  function automatic logic [7:0] reg_default(input logic [`ADDR_W-1:0] a);
    reg_default = (a == `REG_SIDETONE) ? `SIDETONE_DEFAULT : `REG_DEFAULT;
  endfunction

  // Pin synchronisers; first stage feeds only the second
  logic [2:0] sync1_reg, sync1_next;
  logic [2:0] sync2_reg, sync2_next;
  logic       bclk_d_reg, fs_d_reg;
  logic       pd_pin, fs_pin, bclk_pin, bclk_rise, fs_rise;

  always_comb begin
    sync1_next = {bit_clk, frame_sync, power_down_pin};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_reg  <= 3'h0;
      sync2_reg  <= 3'h0;
      bclk_d_reg <= 1'b0;
      fs_d_reg   <= 1'b0;
    end else begin
      sync1_reg  <= sync1_next;
      sync2_reg  <= sync2_next;
      bclk_d_reg <= sync2_reg[2];
      fs_d_reg   <= sync2_reg[1];
    end
  end

  assign pd_pin    = sync2_reg[0];
  assign fs_pin    = sync2_reg[1];
  assign bclk_pin  = sync2_reg[2];
  assign bclk_rise = bclk_pin & ~bclk_d_reg;
  assign fs_rise   = fs_pin & ~fs_d_reg;

  // Register file; power-down never reaches it, only resets do
  logic [7:0] regs_reg  [`REG_FIRST:`REG_LAST];
  logic [7:0] regs_next [`REG_FIRST:`REG_LAST];
  logic       swr1, swr2;

  assign swr1 = regs_reg[`REG_CODEC1_CTRL][`BIT_SW_RESET];
  assign swr2 = regs_reg[`REG_CODEC2_CTRL][`BIT_SW_RESET];

  always_comb begin
    for (int i = `REG_FIRST; i <= `REG_LAST; i++) begin
      if ((swr1 && in_group1(5'(i))) || (swr2 && in_group2(5'(i)))) begin
        regs_next[i] = reg_default(5'(i));
      end else if (reg_write && reg_addr == 5'(i)) begin
        regs_next[i] = reg_wdata;
      end else begin
        regs_next[i] = regs_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = `REG_FIRST; i <= `REG_LAST; i++) begin
      if (!nrst) begin
        regs_reg[i] <= reg_default(5'(i));
      end else begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end

  // Frame timing and codec counters
  logic [7:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] c1_cnt_reg, c1_cnt_next, c2_cnt_reg, c2_cnt_next;
  logic       clr1, clr2, c1_pd, c2_pd;

  assign c1_pd = regs_reg[`REG_CODEC1_CTRL][`BIT_CODEC_PD];
  assign c2_pd = regs_reg[`REG_CODEC2_CTRL][`BIT_CODEC_PD];
  assign clr1  = pd_pin | c1_pd | swr1;
  assign clr2  = pd_pin | c2_pd | swr2;

  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    if (pd_pin || fs_rise) begin
      bit_cnt_next = 8'h00;
    end else if (bclk_rise) begin
      bit_cnt_next = bit_cnt_reg + 8'h01;
    end
    c1_cnt_next = clr1 ? 8'h00 : c1_cnt_reg + {7'h00, fs_rise};
    c2_cnt_next = clr2 ? 8'h00 : c2_cnt_reg + {7'h00, fs_rise};
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bit_cnt_reg <= 8'h00;
      c1_cnt_reg  <= 8'h00;
      c2_cnt_reg  <= 8'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      c1_cnt_reg  <= c1_cnt_next;
      c2_cnt_reg  <= c2_cnt_next;
    end
  end

  // Host access gating after reset, power-down release and software reset
  link_state_e lnk_reg, lnk_next;
  logic [8:0]  wait_reg, wait_next;
  logic [1:0]  fs_seen_reg, fs_seen_next;
  logic        pd_fall;
  logic        pd_d_reg;

  assign pd_fall = ~pd_pin & pd_d_reg;

  always_comb begin
    lnk_next     = lnk_reg;
    wait_next    = wait_reg;
    fs_seen_next = fs_seen_reg;
    case (lnk_reg)
      LNK_RST_WAIT: begin
        wait_next = wait_reg + 9'h001;
        if (wait_reg == 9'(WAIT_CYC - 1)) begin
          lnk_next = LNK_READY;
        end
      end
      LNK_PD_WAIT: begin
        if (fs_rise) begin
          fs_seen_next = fs_seen_reg + 2'h1;
        end
        if (fs_rise && fs_seen_reg == `PD_WAIT_FRAMES - 2'h1) begin
          lnk_next = LNK_READY;
        end
      end
      LNK_SWR_WAIT: begin
        if (fs_rise) begin
          lnk_next = LNK_READY;
        end
      end
      LNK_READY: begin
      end
      default: begin
        lnk_next = LNK_RST_WAIT;
      end
    endcase
    // Power-down outranks a software reset wait
    if (pd_pin || pd_fall) begin
      lnk_next     = LNK_PD_WAIT;
      fs_seen_next = 2'h0;
    end else if ((swr1 || swr2) && lnk_reg != LNK_RST_WAIT) begin
      lnk_next = LNK_SWR_WAIT;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lnk_reg     <= LNK_RST_WAIT;
      wait_reg    <= 9'h000;
      fs_seen_reg <= 2'h0;
      pd_d_reg    <= 1'b0;
    end else begin
      lnk_reg     <= lnk_next;
      wait_reg    <= wait_next;
      fs_seen_reg <= fs_seen_next;
      pd_d_reg    <= pd_pin;
    end
  end

  // Registered outputs
  pd_ctrl_s   pd_next;
  gain_ctrl_s gain_next;
  logic [7:0] rdata_next;
  logic [2:0] spk_code;

  always_comb begin
    spk_code                 = regs_reg[`REG_SPK_GAIN][2:0];
    pd_next.hw_pd            = pd_pin;
    pd_next.codec1_pd        = c1_pd;
    pd_next.codec2_pd        = c2_pd;
    pd_next.analog_pd        = regs_reg[`REG_ANALOG][`BIT_ANALOG_PD];
    pd_next.handset_drv_pd   = regs_reg[`REG_HS_DRV][`BIT_DRV_PD];
    pd_next.headset_drv_pd   = regs_reg[`REG_ANALOG][`BIT_HD_DRV_PD];
    pd_next.line_drv_pd      = regs_reg[`REG_ANALOG][`BIT_LN_DRV_PD];
    pd_next.speaker_drv_pd   = regs_reg[`REG_SPK_DRV][`BIT_DRV_PD];
    gain_next.handset_mic_input =
      mic_gain_e'(regs_reg[`REG_MIC_GAIN][`GAIN_HS_LSB +: 2]);
    gain_next.headset_mic_input =
      mic_gain_e'(regs_reg[`REG_MIC_GAIN][`GAIN_HD_LSB +: 2]);
    // Codes past the table mute, so no stray code gives gain
    gain_next.speakerphone_mic_input =
      (spk_code > 3'h4) ? SPK_MUTE : spk_gain_e'(spk_code);
    gain_next.handset_sidetone =
      regs_reg[`REG_SIDETONE][`SIDE_HS_LSB +: 4];
    gain_next.headset_sidetone =
      regs_reg[`REG_SIDETONE][`SIDE_HD_LSB +: 4];
    rdata_next = 8'h00;
    if (reg_read) begin
      if (reg_addr >= `REG_FIRST && reg_addr <= `REG_LAST) begin
        rdata_next = regs_reg[reg_addr];
      end else if (reg_addr == `REG_STATUS) begin
        rdata_next = {5'h00, lnk_reg == LNK_READY, c1_pd | c2_pd, pd_pin};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pd_ctrl       <= '0;
      gain_ctrl     <= '0;
      reg_rdata     <= 8'h00;
      frame_slot    <= 4'h0;
      codec1_frames <= 8'h00;
      codec2_frames <= 8'h00;
      codec1_reset  <= 1'b1;
      codec2_reset  <= 1'b1;
      host_ready    <= 1'b0;
    end else begin
      pd_ctrl       <= pd_next;
      gain_ctrl     <= gain_next;
      reg_rdata     <= rdata_next;
      frame_slot    <= bit_cnt_reg[7:4];
      codec1_frames <= c1_cnt_reg;
      codec2_frames <= c2_cnt_reg;
      codec1_reset  <= swr1;
      codec2_reset  <= swr2;
      host_ready    <= lnk_reg == LNK_READY;
    end
  end

  // Checks
  a_hwpd_follow_pin: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(pd_pin) |=> pd_ctrl.hw_pd)
    else $error("hardware power-down output did not follow pin");

  a_regs_kept_pd: assert property (
    @(posedge clk) disable iff (!nrst)
    (pd_pin && !reg_write && !swr1 && !swr2) |=>
      regs_reg[`REG_ANALOG] == $past(regs_reg[`REG_ANALOG]))
    else $error("register changed during hardware power-down");

  a_cnt_clear_hw: assert property (
    @(posedge clk) disable iff (!nrst)
    pd_pin |=> (c1_cnt_reg == 8'h00 && c2_cnt_reg == 8'h00
                && bit_cnt_reg == 8'h00))
    else $error("counters not cleared in hardware power-down");

  a_codec_cnt_clr: assert property (
    @(posedge clk) disable iff (!nrst)
    (c1_pd && !reg_write && !swr1) |=> c1_cnt_reg == 8'h00 ##0
      regs_reg[`REG_CODEC1_CTRL] == $past(regs_reg[`REG_CODEC1_CTRL]))
    else $error("codec power-down did not clear counter only");

  a_analog_pd_out: assert property (
    @(posedge clk) disable iff (!nrst)
    regs_reg[`REG_ANALOG][`BIT_ANALOG_PD] |=> pd_ctrl.analog_pd)
    else $error("analog master power-down not driven");

  a_drv_pd_out: assert property (
    @(posedge clk) disable iff (!nrst)
    regs_reg[`REG_HS_DRV][`BIT_DRV_PD] != regs_reg[`REG_SPK_DRV][`BIT_DRV_PD]
      |=> pd_ctrl.handset_drv_pd != pd_ctrl.speaker_drv_pd)
    else $error("driver power-downs not independent");

  a_swreset_grp1: assert property (
    @(posedge clk) disable iff (!nrst)
    swr1 |=> regs_reg[`REG_CODEC1_CTRL] == `REG_DEFAULT ##1 !codec1_reset)
    else $error("register 2 reset did not default group");

  a_swreset_grp2: assert property (
    @(posedge clk) disable iff (!nrst)
    swr2 |=> regs_reg[`REG_SIDETONE] == `SIDETONE_DEFAULT
      && regs_reg[`REG_ANALOG] == `REG_DEFAULT)
    else $error("register 7 reset did not default group");

  a_ready_after_pd: assert property (
    @(posedge clk) disable iff (!nrst)
    pd_fall |-> !host_ready [*3])
    else $error("ready raised too soon after power-down");

  // Power-down takes the link over, so only a plain reset is checked
  a_swr_link_wait: assert property (
    @(posedge clk) disable iff (!nrst)
    ((swr1 || swr2) && !pd_pin && !pd_fall && lnk_reg != LNK_RST_WAIT)
      |=> lnk_reg == LNK_SWR_WAIT ##1 !host_ready)
    else $error("software reset did not hold off host traffic");

  a_reset_wait: assert property (
    @(posedge clk)
    $rose(nrst) |-> !host_ready [*8])
    else $error("ready raised too soon after reset");

endmodule // codec_power_reset

`default_nettype wire

// *** sim/host_dsp_model.sv ***
// Purpose: Host side: free running bit clock and frame sync
// Assumes: 5 MHz bit clock, frames back to back
// Notes:   Phase offset keeps it unrelated to the block clock
`timescale 1ns/1ps
`default_nettype none

module host_dsp_model (
  output logic bit_clk,
  output logic frame_sync
);
  logic [7:0] bit_cnt;

  initial begin
    bit_clk = 1'b0;
    bit_cnt = 8'hFF;
    frame_sync = 1'b0;
    #7;
    forever #100 bit_clk = ~bit_clk;
  end

  // One pulse per 256 bit clocks starts each frame
  always @(posedge bit_clk) begin
    bit_cnt <= bit_cnt + 8'h01;
    frame_sync <= (bit_cnt == 8'hFF);
  end
endmodule // host_dsp_model
`default_nettype wire

// *** sim/tb.sv ***
// Purpose: Self-checking bench of the power-down and reset block
// Assumes: Register mirror tracks writes and group resets
// Notes:   Reads are checked from a queue by a separate monitor
`include "pwr_rst_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb
  import pwr_rst_pkg::*;
;
  logic               clk, nrst, reg_write, reg_read, power_down_pin;
  logic               frame_sync, bit_clk, codec1_reset, codec2_reset;
  logic               host_ready, rd_pend;
  logic [`ADDR_W-1:0] reg_addr;
  logic [7:0]         reg_wdata, reg_rdata, codec1_frames, codec2_frames;
  logic [7:0]         seed, f, g;
  logic [3:0]         frame_slot;
  pd_ctrl_s           pd_ctrl;
  gain_ctrl_s         gain_ctrl;
  logic [7:0]         exp_regs [0:19];
  logic [7:0]         q [$];
  int                 num_errors, n_checks;
  logic [4:0]         pd_a [7] = '{5'h02, 5'h07, 5'h0E, 5'h0D, 5'h0E,
                                   5'h0E, 5'h0B};
  logic [7:0]         pd_d [7] = '{8'h40, 8'h40, 8'h80, 8'h80, 8'h40,
                                   8'h20, 8'h80};
  logic [7:0]         pd_m [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
                                   8'h02, 8'h01};

  codec_power_reset i_codec_power_reset (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .power_down_pin(power_down_pin), .frame_sync(frame_sync),
    .bit_clk(bit_clk), .pd_ctrl(pd_ctrl), .gain_ctrl(gain_ctrl),
    .frame_slot(frame_slot), .codec1_frames(codec1_frames),
    .codec2_frames(codec2_frames), .codec1_reset(codec1_reset),
    .codec2_reset(codec2_reset), .host_ready(host_ready)
  );

  host_dsp_model i_host_dsp_model (
    .bit_clk(bit_clk),
    .frame_sync(frame_sync)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Mirror of a software reset: group 1 is regs 1-5 and 15
  task automatic grp(input int n);
    for (int a = 1; a <= 17; a++) begin
      if ((n == 1) == (a <= 5 || a == 15)) begin
        exp_regs[a] = (a == 6) ? 8'h44 : 8'h00;
      end
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    if (a >= 1 && a <= 17) exp_regs[a] = d;
    if ((a == 2 || a == 7) && d[7]) grp(a == 2 ? 1 : 2);
  endtask

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    q.push_back(exp_regs[a]);
    @(posedge clk);
    reg_read <= 1'b0;
  endtask

  // Status at 18 is skipped; 0 and 19 are unmapped
  task automatic rd_all();
    for (int a = 0; a <= 17; a++) rd(5'(a));
    rd(5'h13);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait; a timeout is counted by the check and ends the run
  task automatic wait_ready(input int lim);
    int i;
    for (i = 0; i < lim && host_ready !== 1'b1; i++) @(negedge clk);
    chk(host_ready, 1'b1);
    if (i == lim) finish_test();
  endtask

  always @(posedge clk) begin
    if (rd_pend) chk(reg_rdata, q.pop_front());
    rd_pend <= reg_read;
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  initial begin
    nrst = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    power_down_pin = 1'b0;
    rd_pend = 1'b0;
    seed = 8'h57;
    num_errors = 0;
    n_checks = 0;
    for (int a = 0; a < 20; a++) exp_regs[a] = 8'h00;
    exp_regs[6] = 8'h44;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    cyc(395);
    chk(host_ready, 1'b0);
    wait_ready(20);
    chk(gain_ctrl.handset_sidetone, 4'h4);
    chk(gain_ctrl.headset_sidetone, 4'h4);
    wr(5'h00, 8'hFF);
    rd_all();
    for (int i = 0; i < 7; i++) begin
      wr(pd_a[i], pd_d[i]);
      cyc(3);
      chk(pd_ctrl, pd_m[i]);
      if (i == 0) chk(codec1_frames, 8'h00);
      wr(pd_a[i], 8'h00);
    end
    for (int v = 0; v < 5; v++) begin
      wr(`REG_MIC_GAIN, {4'h0, 2'(v), 2'(v)});
      wr(`REG_SPK_GAIN, 8'(v));
      cyc(2);
      if (v < 4) chk(gain_ctrl.handset_mic_input, 16'(v));
      if (v < 4) chk(gain_ctrl.headset_mic_input, 16'(v));
      chk(gain_ctrl.speakerphone_mic_input, 16'(v));
    end
    // Reset bits masked so the random fill keeps every register
    for (int a = 1; a <= 17; a++) begin
      seed = lfsr(seed);
      wr(5'(a), (a == 2 || a == 7) ? (seed & 8'h7F) : seed);
    end
    rd_all();
    power_down_pin <= 1'b1;
    cyc(5);
    chk(pd_ctrl.hw_pd, 1'b1);
    chk(codec1_frames, 8'h00);
    chk(codec2_frames, 8'h00);
    rd_all();
    exp_regs[18] = {5'h00, 1'b0, exp_regs[2][6] | exp_regs[7][6], 1'b1};
    rd(5'h12);
    power_down_pin <= 1'b0;
    cyc(5);
    chk(pd_ctrl.hw_pd, 1'b0);
    cyc(2030);
    chk(host_ready, 1'b0);
    wait_ready(2200);
    wr(5'h02, 8'h80);
    cyc(2);
    chk(codec1_reset, 1'b1);
    chk(codec2_reset, 1'b0);
    cyc(1);
    chk(codec1_reset, 1'b0);
    chk(codec1_frames, 8'h00);
    chk(host_ready, 1'b0);
    wait_ready(2100);
    rd_all();
    wr(5'h07, 8'h80);
    cyc(2);
    chk(codec2_reset, 1'b1);
    chk(codec1_reset, 1'b0);
    cyc(1);
    chk(codec2_frames, 8'h00);
    chk(host_ready, 1'b0);
    wait_ready(2100);
    chk(frame_slot, 4'h0);
    rd_all();
    exp_regs[18] = 8'h04;
    rd(5'h12);
    cyc(10);
    f = codec1_frames;
    g = codec2_frames;
    cyc(2048);
    chk(codec1_frames, f + 8'h01);
    chk(codec2_frames, g + 8'h01);
    // About 450 cycles into the frame: 56 bit clocks, slot 3
    cyc(400);
    chk(frame_slot, 4'h3);
    finish_test();
  end
endmodule // tb
`default_nettype wire
